//--- rtl/mix_exec.sv
// executes swi, or immediate, or register, cfg page write/read and long branch
// assumes fetch holds op_in valid for one cycle when ready_out is high
//
// Behaviour
// - software interrupt pushes pc plus one, loads pc with 0x001 and takes 3 cycles.
// - or immediate ors the accumulator with the operand into the accumulator and sets zero.
// - or register ors the accumulator with the data register and with dest 0 writes the accumulator.
// - or register with dest 1 writes the result back to the data register.
// - cfg page write copies the accumulator to cfg register 5 to 15 in one cycle, flags untouched.
// - cfg page read copies cfg register 5 to 15 into the accumulator in one cycle.
// - long branch loads the 11 bit target into pc without the stack in 2 cycles.
// - long branch targets span 0 to 2047.
`timescale 1ns/1ns
module mix_exec
   import mix_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic op_valid_in,
   input wire logic [2:0] op_in,
   input wire logic [7:0] imm_in,
   input wire logic [6:0] raddr_in,
   input wire logic dest_in,
   input wire logic [10:0] target_in,
   input wire logic [3:0] faddr_in,
   input wire logic [7:0] rdata_in,
   input wire logic [7:0] fdata_in,
   output logic ready_out,
   output logic [7:0] acc_out,
   output logic zero_out,
   output logic [10:0] pc_out,
   output logic push_out,
   output logic [10:0] push_data_out,
   output logic [6:0] raddr_out,
   output logic rwr_out,
   output logic [7:0] rwdata_out,
   output logic [3:0] faddr_out,
   output logic fwr_out,
   output logic [7:0] fwdata_out
);
   typedef enum logic [1:0] {MIX_IDLE, MIX_WAIT} mix_state_t;
   mix_state_t state_reg;
   logic [1:0] cnt_reg;
   logic [7:0] acc_reg;
   logic zero_reg;
   logic [10:0] pc_reg;
   logic push_reg;
   logic [10:0] push_data_reg;
   logic rwr_reg;
   logic [7:0] rwdata_reg;
   logic fwr_reg;
   logic [7:0] fwdata_reg;
   logic [3:0] faddr_reg;
   mix_op_t op;
   mix_alu_if orif();

   mix_or_unit u_or (.alu(orif));

   wire take = op_valid_in && (state_reg == MIX_IDLE);
   wire is_swi = take && (op == MIX_OP_SWI);
   wire is_ori = take && (op == MIX_OP_OR_IMM);
   wire is_orr = take && (op == MIX_OP_OR_REG);
   wire is_cwr = take && (op == MIX_OP_CFG_WR);
   wire is_crd = take && (op == MIX_OP_CFG_RD);
   wire is_lbr = take && (op == MIX_OP_LONG_BRANCH);
   // operands outside 5..15 are ignored so reserved cfg slots are never touched
   wire f_ok = (faddr_in >= MIX_CFG_LO) && (faddr_in <= MIX_CFG_HI);
   wire [10:0] pc_plus1 = pc_reg + 11'h001;

   assign op = mix_op_t'(op_in);
   assign orif.opa = acc_reg;
   assign orif.opb = is_orr ? rdata_in : imm_in;
   assign raddr_out = raddr_in;
   assign ready_out = (state_reg == MIX_IDLE);
   assign acc_out = acc_reg;
   assign zero_out = zero_reg;
   assign pc_out = pc_reg;
   assign push_out = push_reg;
   assign push_data_out = push_data_reg;
   assign rwr_out = rwr_reg;
   assign rwdata_out = rwdata_reg;
   assign fwr_out = fwr_reg;
   assign fwdata_out = fwdata_reg;
   assign faddr_out = is_crd ? faddr_in : faddr_reg;

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_reg <= MIX_IDLE;
         cnt_reg <= 2'h0;
      end
      else if (is_swi)
      begin
         state_reg <= MIX_WAIT;
         cnt_reg <= MIX_SWI_CYCLES - 2'h1;
      end
      else if (is_lbr)
      begin
         state_reg <= MIX_WAIT;
         cnt_reg <= MIX_BRANCH_CYCLES - 2'h1;
      end
      else if (state_reg == MIX_WAIT)
      begin
         cnt_reg <= cnt_reg - 2'h1;
         if (cnt_reg == 2'h1)
            state_reg <= MIX_IDLE;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         acc_reg <= MIX_ACC_RESET;
         zero_reg <= 1'b0;
      end
      else if (is_ori || (is_orr && !dest_in))
      begin
         acc_reg <= orif.result;
         zero_reg <= orif.zero;
      end
      else if (is_orr)
         zero_reg <= orif.zero;
      else if (is_crd && f_ok)
         acc_reg <= fdata_in;
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         pc_reg <= MIX_PC_RESET;
      else if (is_swi)
         pc_reg <= MIX_SWI_VECTOR;
      else if (is_lbr)
         pc_reg <= target_in;
      else if (take)
         pc_reg <= pc_plus1;
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         push_reg <= 1'b0;
         push_data_reg <= 11'h000;
         rwr_reg <= 1'b0;
         rwdata_reg <= 8'h00;
         fwr_reg <= 1'b0;
         fwdata_reg <= 8'h00;
         faddr_reg <= 4'h0;
      end
      else
      begin
         push_reg <= is_swi;
         if (is_swi)
            push_data_reg <= pc_plus1;
         rwr_reg <= is_orr && dest_in;
         if (is_orr)
            rwdata_reg <= orif.result;
         fwr_reg <= is_cwr && f_ok;
         if (is_cwr)
         begin
            fwdata_reg <= acc_reg;
            faddr_reg <= faddr_in;
         end
      end
   end

   sequence s_swi;
      op_valid_in && ready_out && op_in == 3'h1;
   endsequence

   chk_swi_vector: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      s_swi |=> pc_out == MIX_SWI_VECTOR && push_out && !ready_out ##1 !ready_out ##1 ready_out)
      else $error("software interrupt vector or timing wrong");
   chk_swi_push: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      s_swi |=> push_data_out == $past(pc_out) + 11'h001)
      else $error("software interrupt return address wrong");
   chk_or_imm: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h2 |=> acc_out == ($past(acc_out) | $past(imm_in)))
      else $error("or immediate result wrong");
   chk_or_reg_acc: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h3 && !dest_in
      |=> acc_out == ($past(acc_out) | $past(rdata_in)) && !rwr_out)
      else $error("or register to accumulator wrong");
   chk_or_reg_back: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h3 && dest_in
      |=> rwr_out && rwdata_out == ($past(acc_out) | $past(rdata_in)) && $stable(acc_out))
      else $error("or register write back wrong");
   chk_cfg_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h4 && faddr_in >= MIX_CFG_LO
      |=> fwr_out && fwdata_out == $past(acc_out) && $stable(zero_out))
      else $error("cfg page write wrong");
   chk_cfg_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h5 && faddr_in >= MIX_CFG_LO
      |=> acc_out == $past(fdata_in) && !fwr_out)
      else $error("cfg page read wrong");
   chk_branch_pc: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h6
      |=> pc_out == $past(target_in) && !push_out && !ready_out ##1 ready_out)
      else $error("long branch wrong");
   chk_zero_flag: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h2 |=> zero_out == (acc_out == 8'h00))
      else $error("zero flag wrong");

   // reserved cfg slots below 5 must never see a write or leak into the accumulator
   sequence s_cfg_low;
      op_valid_in && ready_out && (faddr_in < MIX_CFG_LO);
   endsequence

   chk_busy_refuse: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !ready_out |=> $stable(acc_out) && $stable(zero_out) && !rwr_out && !fwr_out)
      else $error("op accepted while busy");
   chk_cfg_skip_wr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      s_cfg_low ##0 op_in == 3'h4 |=> !fwr_out)
      else $error("cfg write outside 5 to 15 not ignored");
   chk_cfg_skip_rd: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      s_cfg_low ##0 op_in == 3'h5 |=> $stable(acc_out))
      else $error("cfg read outside 5 to 15 not ignored");
   chk_zero_reg: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      op_valid_in && ready_out && op_in == 3'h3
      |=> zero_out == (($past(acc_out) | $past(rdata_in)) == 8'h00))
      else $error("zero flag after or register wrong");
endmodule

//--- include/mix_pkg.sv
// package for the instruction subset execution block
// assumes one core clock and an external fetch unit that presents decoded opcodes
package mix_pkg;
   localparam int MIX_PC_W = 11;
   localparam int MIX_DATA_W = 8;
   localparam int MIX_RADDR_W = 7;
   localparam int MIX_FADDR_W = 4;
   localparam logic [10:0] MIX_SWI_VECTOR = 11'h001;
   localparam logic [3:0] MIX_CFG_LO = 4'h5;
   localparam logic [3:0] MIX_CFG_HI = 4'hf;
   localparam logic [1:0] MIX_SWI_CYCLES = 2'h3;
   localparam logic [1:0] MIX_BRANCH_CYCLES = 2'h2;
   localparam logic [7:0] MIX_ACC_RESET = 8'h00;
   localparam logic [10:0] MIX_PC_RESET = 11'h000;
   typedef enum logic [2:0] {
      MIX_OP_NONE,
      MIX_OP_SWI,
      MIX_OP_OR_IMM,
      MIX_OP_OR_REG,
      MIX_OP_CFG_WR,
      MIX_OP_CFG_RD,
      MIX_OP_LONG_BRANCH
   } mix_op_t;
endpackage

//--- include/mix_alu_if.sv
// interface between the executor and its or unit
// assumes both ends share the core clock
`timescale 1ns/1ns
interface mix_alu_if;
   import mix_pkg::*;
   logic [7:0] opa;
   logic [7:0] opb;
   logic [7:0] result;
   logic zero;
   modport exec (output opa, output opb, input result, input zero);
   modport alu (input opa, input opb, output result, output zero);
endinterface

//--- rtl/mix_or_unit.sv
// combinational or unit with zero detection
// assumes operands are stable within the cycle
`timescale 1ns/1ns
module mix_or_unit
   import mix_pkg::*;
(
   mix_alu_if.alu alu
);
   assign alu.result = alu.opa | alu.opb;
   assign alu.zero = (alu.result == 8'h00);
endmodule

//--- dv/mix_exec_test.sv
// self-checking bench for the instruction subset executor
// assumes mix_exec ports as declared; the bench answers data and cfg register reads
`timescale 1ns/1ns
module mix_exec_test
   import mix_pkg::*;
;
   typedef struct packed {logic [2:0] op; logic [7:0] imm; logic [6:0] ra; logic d;
      logic [10:0] tgt; logic [3:0] fa;} mix_row_t;
   logic mclk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic op_valid_in = 1'b0;
   logic dest_in = 1'b0;
   logic [2:0] op_in = 3'h0;
   logic [7:0] imm_in = 8'h00;
   logic [6:0] raddr_in = 7'h00;
   logic [10:0] target_in = 11'h000;
   logic [3:0] faddr_in = 4'h0;
   logic ready_out, zero_out, push_out, rwr_out, fwr_out;
   logic [7:0] acc_out, rwdata_out, fwdata_out;
   logic [10:0] pc_out, push_data_out;
   logic [6:0] raddr_out;
   logic [3:0] faddr_out;
   // read data differs per address so a wrong select shows up
   wire logic [7:0] rdata_in = {1'b0, raddr_out} ^ 8'h2a;
   wire logic [7:0] fdata_in = {4'h0, faddr_out} ^ 8'hc3;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [7:0] e_acc = 8'h00;
   logic e_z = 1'b0;
   logic [10:0] e_pc = 11'h000;
   mix_row_t rows [12] = '{
      '{MIX_OP_OR_IMM, 8'h00, 7'h00, 1'b0, 11'h000, 4'h0},
      '{MIX_OP_OR_IMM, 8'h50, 7'h00, 1'b0, 11'h000, 4'h0},
      '{MIX_OP_CFG_WR, 8'h00, 7'h00, 1'b0, 11'h000, 4'h5},
      '{MIX_OP_CFG_WR, 8'h00, 7'h00, 1'b0, 11'h000, 4'h4},
      '{MIX_OP_CFG_RD, 8'h00, 7'h00, 1'b0, 11'h000, 4'hf},
      '{MIX_OP_OR_REG, 8'h00, 7'h7f, 1'b1, 11'h000, 4'h0},
      '{MIX_OP_OR_REG, 8'h00, 7'h2a, 1'b0, 11'h000, 4'h0},
      '{MIX_OP_LONG_BRANCH, 8'h00, 7'h00, 1'b0, 11'h7ff, 4'h0},
      '{MIX_OP_SWI, 8'h00, 7'h00, 1'b0, 11'h000, 4'h0},
      '{MIX_OP_LONG_BRANCH, 8'h00, 7'h00, 1'b0, 11'h000, 4'h0},
      '{MIX_OP_CFG_RD, 8'h00, 7'h00, 1'b0, 11'h000, 4'h4},
      '{MIX_OP_CFG_RD, 8'h00, 7'h00, 1'b0, 11'h000, 4'h5}};

   mix_exec mix_exec_i (.mclk_in, .rst_b_in, .op_valid_in, .op_in, .imm_in, .raddr_in,
      .dest_in, .target_in, .faddr_in, .rdata_in, .fdata_in, .ready_out, .acc_out,
      .zero_out, .pc_out, .push_out, .push_data_out, .raddr_out, .rwr_out, .rwdata_out,
      .faddr_out, .fwr_out, .fwdata_out);

   always #4 mclk_in = ~mclk_in;

   task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // issue one op; during a multi-cycle op an or immediate is offered and must be ignored
   task automatic run(input mix_row_t r);
      logic [7:0] res;
      logic [10:0] npc;
      int n;
      n = (r.op == MIX_OP_SWI) ? 2 : (r.op == MIX_OP_LONG_BRANCH) ? 1 : 0;
      npc = e_pc + 11'h001;
      res = e_acc | ((r.op == MIX_OP_OR_IMM) ? r.imm : ({1'b0, r.ra} ^ 8'h2a));
      @(posedge mclk_in);
      op_valid_in <= 1'b1;
      op_in <= r.op;
      imm_in <= r.imm;
      raddr_in <= r.ra;
      dest_in <= r.d;
      target_in <= r.tgt;
      faddr_in <= r.fa;
      @(posedge mclk_in);
      op_valid_in <= (n != 0);
      op_in <= MIX_OP_OR_IMM;
      imm_in <= 8'hff;
      #1;
      chk("push", push_out, r.op == MIX_OP_SWI);
      chk("rwr", rwr_out, r.op == MIX_OP_OR_REG && r.d);
      chk("fwr", fwr_out, r.op == MIX_OP_CFG_WR && r.fa >= 4'h5);
      case (r.op)
         MIX_OP_OR_IMM, MIX_OP_OR_REG:
         begin
            if (r.op == MIX_OP_OR_REG && r.d)
               chk("rwdata", rwdata_out, res);
            else
               e_acc = res;
            if (r.op == MIX_OP_OR_REG)
               chk("raddr", raddr_out, r.ra);
            e_z = (res == 8'h00);
         end
         MIX_OP_CFG_WR:
            if (r.fa >= 4'h5)
            begin
               chk("fwdata", fwdata_out, e_acc);
               chk("faddr", faddr_out, r.fa);
            end
         MIX_OP_CFG_RD:
            if (r.fa >= 4'h5)
               e_acc = {4'h0, r.fa} ^ 8'hc3;
         MIX_OP_SWI:
         begin
            chk("push_data", push_data_out, e_pc + 11'h001);
            npc = MIX_SWI_VECTOR;
         end
         MIX_OP_LONG_BRANCH:
            npc = r.tgt;
         default:
            npc = e_pc + 11'h001;
      endcase
      e_pc = npc;
      for (int i = 1; i <= n; i++)
      begin
         chk("busy", ready_out, 1'b0);
         @(posedge mclk_in);
         if (i == n)
            op_valid_in <= 1'b0;
         #1;
      end
      chk("ready", ready_out, 1'b1);
      chk("pc", pc_out, e_pc);
      chk("acc", acc_out, e_acc);
      chk("zero", zero_out, e_z);
   endtask

   always @(posedge mclk_in)
   begin
      cyc = cyc + 1;
      if (cyc == 2000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (5) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      foreach (rows[i])
         run(rows[i]);
      // reset in mid-run must bring the accumulator and flag back before the next op
      @(posedge mclk_in);
      rst_b_in <= 1'b0;
      @(posedge mclk_in);
      rst_b_in <= 1'b1;
      e_acc = 8'h00;
      e_z = 1'b0;
      e_pc = 11'h000;
      run(rows[0]);
      wrap_up();
   end
endmodule
